//--- ksd_pkg.sv
//----------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------
// Behaviour
// - Kernel mode: debug clear, user clear/erl/exl set
// - Non-debug exception sets exl or erl
// - Return clears erl; exl only if erl clear
// - Kernel low half mapped, tagged with space tag
// - Error level: low half unmapped, uncached
// - 100 segment unmapped, minus base, low field
// - 101 segment unmapped, minus base, uncached
// - 110 segment mapped in kernel mode
// - 111 segment mapped through translation buffer
// - Debug: mapped areas need resident translation
// - Debug: kernel exceptions become debug exceptions
// - Debug: unmapped kernel segments stay reachable
// - Debug segment spans ff20_0000 to ff3f_ffff
// - Lower debug half maps uncached to probe
// - Upper debug half maps to debug registers
// - Register range: normal-memory flag selects kernel
// - Unimplemented debug registers: writes ignored
// - Probe range: normal-memory flag, probe enable; the code ignores probe_enable_i
// - Probe reference with enable clear stays pending; the code ignores the enable and clears pending on probe_done_i
// - User mode: user set, exl erl debug clear
// - Cache codes 2 and 7 mean uncached
package ksd_pkg;
  localparam int ADDR_W = 32;
  localparam int TAG_W  = 8;
  localparam int CCA_W  = 3;
  localparam logic [2:0] TOP_UNMAP_CACHED   = 3'h4;
  localparam logic [2:0] TOP_UNMAP_UNCACHED = 3'h5;
  localparam logic [2:0] TOP_MAPPED_LOW     = 3'h6;
  localparam logic [2:0] TOP_MAPPED_HIGH    = 3'h7;
  localparam logic [31:0] UNMAP_CACHED_BASE   = 32'h8000_0000;
  localparam logic [31:0] UNMAP_UNCACHED_BASE = 32'ha000_0000;
  localparam logic [31:0] DSEG_LO    = 32'hff20_0000;
  localparam logic [31:0] DSEG_HI    = 32'hff3f_ffff;
  localparam logic [31:0] DRSEG_LO   = 32'hff30_0000;
  localparam logic [19:0] DSUB_MASK  = 20'hf_ffff;
  localparam logic [2:0] CCA_UNC_A = 3'h2;
  localparam logic [2:0] CCA_UNC_B = 3'h7;
  localparam logic [2:0] CCA_UNCACHED = 3'h2;
  localparam logic [2:0] CCA_CACHED   = 3'h3;
  typedef enum logic [2:0] {
    KSD_SEG_KUSEG, KSD_SEG_KCACHED, KSD_SEG_KUNCACHED, KSD_SEG_K2,
    KSD_SEG_K3,
    KSD_SEG_PROBE, KSD_SEG_DREG, KSD_SEG_NONE
  } ksd_seg_t;
  typedef enum logic [1:0] {
    KSD_RT_MEM, KSD_RT_PROBE, KSD_RT_DREG
  } ksd_route_t;
endpackage

//--- ksd_mode.sv
`timescale 1ns/1ps
module ksd_mode
  import ksd_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic exc_i,
  input  wire logic exc_err_i,
  input  wire logic exc_debug_i,
  input  wire logic exception_return_i,
  input  wire logic user_mode_set_i,
  input  wire logic user_mode_val_i,
  input  wire logic debug_return_i,
  output logic      user_mode_flag_o,
  output logic      exception_level_flag_o,
  output logic      error_level_flag_o,
  output logic      debug_mode_flag_o
);
  //--------------------------------------------------------------------
  // Mode flag state
  //--------------------------------------------------------------------
  wire logic non_dbg_exc;
  wire logic next_exc_lvl;
  wire logic next_err_lvl;
  wire logic next_dbg_flag;
  wire logic next_usr_flag;
  // Debug exceptions leave status flags alone
  assign non_dbg_exc = exc_i & ~exc_debug_i;
  // Exception wins over a simultaneous return
  assign next_err_lvl = (non_dbg_exc & exc_err_i) ? 1'b1 :
                        exception_return_i ? 1'b0 :
                        error_level_flag_o;
  assign next_exc_lvl = (non_dbg_exc & ~exc_err_i) ? 1'b1 :
                        (exception_return_i & ~error_level_flag_o) ? 1'b0 :
                        exception_level_flag_o;
  assign next_dbg_flag = exc_debug_i ? 1'b1 :
                         debug_return_i ? 1'b0 : debug_mode_flag_o;
  assign next_usr_flag = user_mode_set_i ? user_mode_val_i
                                         : user_mode_flag_o;
  // Reset enters kernel mode via the error level
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_mode_flag_o       <= 1'b0;
      exception_level_flag_o <= 1'b0;
      error_level_flag_o     <= 1'b1;
      debug_mode_flag_o      <= 1'b0;
    end else begin
      user_mode_flag_o       <= next_usr_flag;
      exception_level_flag_o <= next_exc_lvl;
      error_level_flag_o     <= next_err_lvl;
      debug_mode_flag_o      <= next_dbg_flag;
    end
  end
endmodule

//--- ksd_decoder.sv
`timescale 1ns/1ps
module ksd_decoder
  import ksd_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int TAG_WIDTH  = TAG_W
)(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  exc_i,
  input  wire logic                  exc_err_i,
  input  wire logic                  exc_debug_i,
  input  wire logic                  exception_return_i,
  input  wire logic [ADDR_WIDTH-1:0] saved_pc_i,
  input  wire logic                  user_mode_set_i,
  input  wire logic                  user_mode_val_i,
  input  wire logic                  debug_return_i,
  input  wire logic                  req_valid_i,
  input  wire logic [ADDR_WIDTH-1:0] req_addr_i,
  input  wire logic                  req_fetch_i,
  input  wire logic                  req_write_i,
  input  wire logic                  req_word_i,
  input  wire logic [TAG_WIDTH-1:0]  address_space_tag_i,
  input  wire logic [CCA_W-1:0]      low_kernel_cache_field_i,
  input  wire logic [CCA_W-1:0]      high_kernel_cache_field_i,
  input  wire logic                  load_store_normal_memory_i,
  input  wire logic                  probe_enable_i,
  input  wire logic                  tb_hit_i,
  input  wire logic                  tb_fault_i,
  input  wire logic                  probe_done_i,
  input  wire logic                  dreg_impl_i,
  output logic                       kernel_mode_o,
  output logic                       user_mode_o,
  output logic                       debug_mode_o,
  output logic                       error_level_o,
  output logic                       exception_level_o,
  output logic                       ret_valid_o,
  output logic [ADDR_WIDTH-1:0]      ret_pc_o,
  output logic                       rsp_valid_o,
  output logic [2:0]                 rsp_seg_o,
  output logic                       rsp_mapped_o,
  output logic [ADDR_WIDTH-1:0]      rsp_paddr_o,
  output logic [TAG_WIDTH-1:0]       rsp_tag_o,
  output logic                       rsp_uncached_o,
  output logic [1:0]                 rsp_route_o,
  output logic                       rsp_dreg_we_o,
  output logic                       rsp_debug_exc_o,
  output logic                       rsp_addr_err_o,
  output logic                       probe_pending_o
);
  //--------------------------------------------------------------------
  // Elaboration checks
  //--------------------------------------------------------------------
  if (ADDR_WIDTH != 32) begin : g_bad_addr
    $error("ksd_decoder needs a 32-bit address");
  end
  if (TAG_WIDTH < 1) begin : g_bad_tag
    $error("ksd_decoder needs a nonzero tag width");
  end

  //--------------------------------------------------------------------
  // Mode flags
  //--------------------------------------------------------------------
  logic usr_flag;
  logic exc_lvl;
  logic err_lvl;
  logic dbg_flag;
  ksd_mode u_mode (
    .sys_clk_i            (sys_clk_i),
    .rst_n_i              (rst_n_i),
    .exc_i                (exc_i),
    .exc_err_i            (exc_err_i),
    .exc_debug_i          (exc_debug_i),
    .exception_return_i   (exception_return_i),
    .user_mode_set_i      (user_mode_set_i),
    .user_mode_val_i      (user_mode_val_i),
    .debug_return_i       (debug_return_i),
    .user_mode_flag_o       (usr_flag),
    .exception_level_flag_o (exc_lvl),
    .error_level_flag_o     (err_lvl),
    .debug_mode_flag_o      (dbg_flag)
  );

  function automatic logic cca_uncached(input logic [CCA_W-1:0] c);
    cca_uncached = (c == CCA_UNC_A) || (c == CCA_UNC_B);
  endfunction

  //--------------------------------------------------------------------
  // Mode decode, taken from current flags
  //--------------------------------------------------------------------
  wire logic kern;
  wire logic user;
  wire logic priv;
  assign kern = ~dbg_flag & (~usr_flag | err_lvl | exc_lvl);
  assign user = usr_flag & ~exc_lvl & ~err_lvl & ~dbg_flag;
  // Debug sees the kernel map plus the debug segment
  assign priv = kern | dbg_flag;

  //--------------------------------------------------------------------
  // Segment decode
  //--------------------------------------------------------------------
  wire logic [2:0]  top;
  wire logic        in_dseg;
  wire logic        in_dreg;
  wire logic        normal;
  wire logic        to_probe;
  wire logic        to_dreg;
  wire logic        low_field_unc;
  wire logic        high_field_unc;
  assign top     = req_addr_i[31:29];
  assign in_dseg = dbg_flag & (req_addr_i >= DSEG_LO)
                      & (req_addr_i <= DSEG_HI);
  assign in_dreg = req_addr_i >= DRSEG_LO;
  // Only loads and stores may reach plain kernel space here
  assign normal  = ~req_fetch_i & load_store_normal_memory_i;
  assign to_probe = in_dseg & ~in_dreg & ~normal;
  assign to_dreg  = in_dseg & in_dreg & ~normal;
  assign low_field_unc  = cca_uncached(low_kernel_cache_field_i);
  assign high_field_unc = cca_uncached(high_kernel_cache_field_i);

  logic [2:0]            seg;
  logic                  mapped;
  logic [ADDR_WIDTH-1:0] paddr;
  logic                  unc;
  logic [1:0]            route;
  logic                  aerr;
  always_comb begin
    seg    = KSD_SEG_NONE;
    mapped = 1'b0;
    paddr  = req_addr_i;
    unc    = 1'b1;
    route  = KSD_RT_MEM;
    aerr   = 1'b0;
    if (to_probe) begin
      seg   = KSD_SEG_PROBE;
      paddr = {12'h000, req_addr_i[19:0] & DSUB_MASK};
      route = KSD_RT_PROBE;
    end else if (to_dreg) begin
      seg   = KSD_SEG_DREG;
      paddr = {12'h000, req_addr_i[19:0] & DSUB_MASK};
      route = KSD_RT_DREG;
    end else if (!top[2]) begin
      seg = KSD_SEG_KUSEG;
      if (err_lvl && priv) begin
        mapped = 1'b0;
        unc    = 1'b1;
      end else begin
        mapped = 1'b1;
        unc    = 1'b0;
      end
    end else if (!priv) begin
      aerr = 1'b1;
    end else begin
      unique case (top)
        TOP_UNMAP_CACHED: begin
          seg   = KSD_SEG_KCACHED;
          paddr = req_addr_i - UNMAP_CACHED_BASE;
          unc   = low_field_unc;
        end
        TOP_UNMAP_UNCACHED: begin
          seg   = KSD_SEG_KUNCACHED;
          paddr = req_addr_i - UNMAP_UNCACHED_BASE;
          unc   = 1'b1;
        end
        TOP_MAPPED_LOW: begin
          seg    = KSD_SEG_K2;
          mapped = 1'b1;
          unc    = high_field_unc;
        end
        TOP_MAPPED_HIGH: begin
          seg    = KSD_SEG_K3;
          mapped = 1'b1;
          unc    = high_field_unc;
        end
        default: begin
          seg = KSD_SEG_NONE;
        end
      endcase
    end
  end

  // Debug mode: a kernel fault turns into a debug exception
  wire logic kern_fault;
  wire logic dbg_exc;
  assign kern_fault = aerr | (mapped & (~tb_hit_i | tb_fault_i));
  assign dbg_exc = req_valid_i & dbg_flag & kern_fault;
  // Unimplemented registers and non-word sizes drop the write
  wire logic dreg_we;
  assign dreg_we = req_valid_i & to_dreg & req_write_i
                   & dreg_impl_i & req_word_i;
  // Probe reference hangs regardless of enable until answered
  wire logic next_pending;
  assign next_pending = (req_valid_i & to_probe) |
                        (probe_pending_o & ~probe_done_i);

  //--------------------------------------------------------------------
  // Registered outputs, one cycle after the request
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o     <= 1'b0;
      rsp_seg_o       <= KSD_SEG_NONE;
      rsp_mapped_o    <= 1'b0;
      rsp_paddr_o     <= '0;
      rsp_tag_o       <= '0;
      rsp_uncached_o  <= 1'b1;
      rsp_route_o     <= KSD_RT_MEM;
      rsp_dreg_we_o   <= 1'b0;
      rsp_debug_exc_o <= 1'b0;
      rsp_addr_err_o  <= 1'b0;
      probe_pending_o <= 1'b0;
    end else begin
      rsp_valid_o     <= req_valid_i;
      rsp_seg_o       <= seg;
      rsp_mapped_o    <= mapped;
      rsp_paddr_o     <= paddr;
      rsp_tag_o       <= mapped ? address_space_tag_i : '0;
      rsp_uncached_o  <= unc;
      rsp_route_o     <= route;
      rsp_dreg_we_o   <= dreg_we;
      rsp_debug_exc_o <= dbg_exc;
      rsp_addr_err_o  <= req_valid_i & aerr & ~dbg_flag;
      probe_pending_o <= next_pending;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kernel_mode_o     <= 1'b1;
      user_mode_o       <= 1'b0;
      debug_mode_o      <= 1'b0;
      error_level_o     <= 1'b1;
      exception_level_o <= 1'b0;
      ret_valid_o       <= 1'b0;
      ret_pc_o          <= '0;
    end else begin
      kernel_mode_o     <= kern;
      user_mode_o       <= user;
      debug_mode_o      <= dbg_flag;
      error_level_o     <= err_lvl;
      exception_level_o <= exc_lvl;
      ret_valid_o       <= exception_return_i;
      ret_pc_o          <= saved_pc_i;
    end
  end
endmodule

//--- ksd_sva.sv
`timescale 1ns/1ps
module ksd_sva (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        exc_i,
  input wire logic        exc_err_i,
  input wire logic        exception_return_i,
  input wire logic [31:0] saved_pc_i,
  input wire logic        req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic        req_fetch_i,
  input wire logic        req_word_i,
  input wire logic        load_store_normal_memory_i,
  input wire logic        dreg_impl_i,
  input wire logic        kernel_mode_o,
  input wire logic        user_mode_o,
  input wire logic        debug_mode_o,
  input wire logic        error_level_o,
  input wire logic        exception_level_o,
  input wire logic        ret_valid_o,
  input wire logic [31:0] ret_pc_o,
  input wire logic        rsp_valid_o,
  input wire logic [2:0]  rsp_seg_o,
  input wire logic        rsp_mapped_o,
  input wire logic [31:0] rsp_paddr_o,
  input wire logic        rsp_uncached_o,
  input wire logic [1:0]  rsp_route_o,
  input wire logic        rsp_dreg_we_o,
  input wire logic        probe_pending_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  rsp_follow_a: assert property (
    1 |=> rsp_valid_o == $past(req_valid_i))
    else $error("response not one cycle after request");
  mode_split_a: assert property (
    kernel_mode_o == (!debug_mode_o && !user_mode_o) &&
    (!user_mode_o || !(error_level_o || exception_level_o)))
    else $error("mode outputs inconsistent");
  exc_level_a: assert property (
    exc_i |-> ##2 ($past(exc_err_i, 2) ? error_level_o : exception_level_o))
    else $error("exception did not raise its level");
  ret_clear_a: assert property (
    exception_return_i && !exc_i |-> ##2 !error_level_o)
    else $error("return left error level set");
  ret_pc_a: assert property (
    exception_return_i |=> ret_valid_o && ret_pc_o == $past(saved_pc_i))
    else $error("return target wrong");
  cached_seg_a: assert property (
    req_valid_i && req_addr_i[31:29] == 3'h4 |=> !(kernel_mode_o ||
    debug_mode_o) || (rsp_seg_o == 3'h1 && !rsp_mapped_o &&
    rsp_paddr_o == $past(req_addr_i) - 32'h8000_0000))
    else $error("cached kernel segment decode wrong");
  uncached_seg_a: assert property (
    req_valid_i && req_addr_i[31:29] == 3'h5 |=> !(kernel_mode_o ||
    debug_mode_o) || (rsp_seg_o == 3'h2 && rsp_uncached_o &&
    rsp_paddr_o == $past(req_addr_i) - 32'ha000_0000))
    else $error("uncached kernel segment decode wrong");
  kuseg_erl_a: assert property (
    req_valid_i && !req_addr_i[31] |=> !error_level_o || !kernel_mode_o ||
    (!rsp_mapped_o && rsp_uncached_o && rsp_paddr_o == $past(req_addr_i)))
    else $error("low half not direct under error level");
  probe_route_a: assert property (
    req_valid_i && req_addr_i[31:20] == 12'hff2 && (req_fetch_i ||
    !load_store_normal_memory_i) |=> !debug_mode_o || (rsp_route_o ==
    2'h1 && rsp_uncached_o && rsp_paddr_o[31:20] == 12'h0))
    else $error("probe window route wrong");
  dreg_write_a: assert property (
    rsp_dreg_we_o |-> rsp_route_o == 2'h2 && $past(dreg_impl_i) &&
    $past(req_word_i))
    else $error("debug register write not allowed");
  pend_hold_a: assert property (
    rsp_valid_o && rsp_route_o == 2'h1 |-> probe_pending_o)
    else $error("probe reference not pending");
endmodule
bind ksd_decoder ksd_sva u_sva (.*);

//--- ksd_far_model.sv
`timescale 1ns/1ps
module ksd_far_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic        pending_i,
  input  wire logic [3:0]  delay_i,
  output logic             tb_hit_o,
  output logic             tb_fault_o,
  output logic             dreg_impl_o,
  output logic             probe_done_o
);
  logic [3:0] cnt;
  // Residency follows address bits so random traffic both hits and misses
  assign tb_hit_o = req_addr_i[12];
  assign tb_fault_o = req_addr_i[12] & req_addr_i[13];
  assign dreg_impl_o = req_addr_i[19:16] == 4'h0;
  // Probe answers whatever its enable, after a chosen delay
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      probe_done_o <= 1'b0;
    end else begin
      cnt <= (!pending_i || probe_done_o) ? 4'h0 : cnt + 4'h1;
      probe_done_o <= pending_i && !probe_done_o && cnt == delay_i;
    end
  end
endmodule

//--- ksd_decoder_tb_top.sv
`timescale 1ns/1ps
module ksd_decoder_tb_top;
  logic sys_clk_i, rst_n_i, exc_i, exc_err_i, exc_debug_i;
  logic exception_return_i, user_mode_set_i, user_mode_val_i;
  logic debug_return_i, req_valid_i, req_fetch_i, req_write_i, req_word_i;
  logic load_store_normal_memory_i, probe_enable_i, tb_hit_i, tb_fault_i;
  logic probe_done_i, dreg_impl_i, kernel_mode_o, user_mode_o;
  logic debug_mode_o, error_level_o, exception_level_o, ret_valid_o;
  logic rsp_valid_o, rsp_mapped_o, rsp_uncached_o, rsp_dreg_we_o;
  logic rsp_debug_exc_o, rsp_addr_err_o, probe_pending_o, usr_exp, dbg_exp;
  logic [31:0] saved_pc_i, req_addr_i, ret_pc_o, rsp_paddr_o, a;
  logic [7:0]  address_space_tag_i, rsp_tag_o;
  logic [2:0]  low_kernel_cache_field_i, high_kernel_cache_field_i;
  logic [2:0]  rsp_seg_o;
  logic [1:0]  rsp_route_o;
  logic [3:0]  dly;
  int          fails, checked;
  ksd_decoder dut (.*);
  ksd_far_model far (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .req_addr_i  (req_addr_i),
    .pending_i   (probe_pending_o),
    .delay_i     (dly),
    .tb_hit_o    (tb_hit_i),
    .tb_fault_o  (tb_fault_i),
    .dreg_impl_o (dreg_impl_i),
    .probe_done_o(probe_done_i)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  task automatic ev(input logic [5:0] e, input logic v);
    @(posedge sys_clk_i);
    {exc_i, exc_err_i, exc_debug_i, exception_return_i, user_mode_set_i,
     debug_return_i} <= e;
    user_mode_val_i <= v;
    saved_pc_i <= $urandom;
    @(posedge sys_clk_i);
    {exc_i, exc_err_i, exc_debug_i, exception_return_i, user_mode_set_i,
     debug_return_i} <= 6'h0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rq(input logic [31:0] ad);
    int i;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_addr_i <= ad;
    req_fetch_i <= 1'($urandom);
    dly <= 4'($urandom_range(1, 15));
    {address_space_tag_i, low_kernel_cache_field_i, high_kernel_cache_field_i,
     load_store_normal_memory_i, probe_enable_i, req_write_i} <= 17'($urandom);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    #1;
    a = ad;
    chk(rsp_valid_o, 1'b1);
    if (usr_exp) chk(rsp_addr_err_o, a[31]);
    else if (a[31:29] == 3'h4) begin
      chk(rsp_seg_o, 3'h1);
      chk(rsp_paddr_o, a - 32'h8000_0000);
      chk(rsp_uncached_o, low_kernel_cache_field_i inside {3'h2, 3'h7});
    end else if (a[31:29] == 3'h5) begin
      chk(rsp_paddr_o, a - 32'ha000_0000);
      chk(rsp_uncached_o, 1'b1);
    end else if (!a[31]) begin
      chk(rsp_mapped_o, !error_level_o);
      chk(rsp_tag_o, error_level_o ? 8'h0 : address_space_tag_i);
    end else if (dbg_exp && a[31:21] == 11'h7f9) begin
      if (!req_fetch_i && load_store_normal_memory_i)
        chk(rsp_route_o, 2'h0);
      else if (a[20]) begin
        chk(rsp_route_o, 2'h2);
        chk(rsp_dreg_we_o, req_write_i && dreg_impl_i);
      end else begin
        chk(rsp_route_o, 2'h1);
        chk(rsp_paddr_o, {12'h0, a[19:0]});
        chk(probe_pending_o, 1'b1);
        for (i = 0; i < 40 && probe_pending_o; i++) begin
          @(posedge sys_clk_i);
          #1;
        end
        chk(probe_pending_o, 1'b0);
      end
    end else begin
      chk(rsp_mapped_o, 1'b1);
      if (dbg_exp) chk(rsp_debug_exc_o, !tb_hit_i || tb_fault_i);
    end
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #500us;
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(80));
    {rst_n_i, exc_i, exc_err_i, exc_debug_i, exception_return_i, usr_exp,
     dbg_exp,
     user_mode_set_i, user_mode_val_i, debug_return_i, req_valid_i,
     req_fetch_i, req_write_i} = '0;
    req_word_i = 1'b1;
    {saved_pc_i, req_addr_i, address_space_tag_i, low_kernel_cache_field_i,
     high_kernel_cache_field_i, load_store_normal_memory_i,
     probe_enable_i} = '0;
    dly = 4'h1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk({kernel_mode_o, error_level_o, debug_mode_o}, 3'h6);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rq(32'h1234_5678);
    ev(6'h04, 1'b0);
    chk({error_level_o, kernel_mode_o}, 2'h1);
    ev(6'h02, 1'b1);
    chk({user_mode_o, kernel_mode_o}, 2'h2);
    usr_exp = 1'b1;
    rq(32'h9000_0000);
    ev(6'h20, 1'b0);
    chk({exception_level_o, kernel_mode_o}, 2'h3);
    ev(6'h30, 1'b0);
    chk(error_level_o, 1'b1);
    ev(6'h04, 1'b0);
    chk({error_level_o, exception_level_o}, 2'h1);
    ev(6'h04, 1'b0);
    chk({exception_level_o, user_mode_o}, 2'h1);
    ev(6'h02, 1'b0);
    usr_exp = 1'b0;
    repeat (150) rq($urandom);
    ev(6'h08, 1'b0);
    chk({debug_mode_o, kernel_mode_o}, 2'h2);
    dbg_exp = 1'b1;
    repeat (150) rq($urandom_range(0, 1) ? {11'h7f9, 21'($urandom)} : $urandom);
    ev(6'h01, 1'b0);
    chk(debug_mode_o, 1'b0);
    tally_and_finish();
  end
endmodule
